// *** design/spapd_ctrl.v ***
// Contract
// - transmitter wakes on holding buffer write
// - receiver wakes on rx input level change
// - config_reg_one bit 2 forces parallel powerdown
// - config_reg_seven bit 4 enables parallel auto powerdown
// - epp down unless enabled and selected
// - ecp down unless enabled, non spp/bidir/epp
// - parallel powerdown re-evaluated on mode changes
// - config_reg_seven bits 5,6 enable serial auto powerdown
// - tx sleeps when buffer and shifter empty
// - rx sleeps when fifo empty and idle
// - ring indicator stays live while powered down
`timescale 1ns/1ns
`include "spapd_defines.vh"
module spapd_ctrl (
   input  wire        clk_in,
   input  wire        rst_in,
   input  wire        ce_in,
   input  wire        wb_cyc_in,
   input  wire        wb_stb_in,
   input  wire        wb_we_in,
   input  wire [7:0]  wb_adr_in,
   input  wire [3:0]  wb_sel_in,
   input  wire [31:0] wb_dat_in,
   output reg  [31:0] wb_dat_out,
   output reg         wb_ack_out,
   input  wire        thb_write_in,
   input  wire        thb_empty_in,
   input  wire        tsr_empty_in,
   input  wire        rx_fifo_empty_in,
   input  wire        rx_idle_in,
   input  wire        serial_rx_input_in,
   input  wire        ring_in,
   output reg         tx_pd_out,
   output reg         rx_pd_out,
   output reg         epp_pd_out,
   output reg         ecp_pd_out,
   output reg         pp_pd_out,
   output reg         ri_change_out
);
   ////////////////////////////////////////////////////////////////
   // serial powerdown states, one-hot
   localparam [1:0] SER_AWAKE  = 2'b01;
   localparam [1:0] SER_ASLEEP = 2'b10;

   ////////////////////////////////////////////////////////////////
   reg  [7:0]  config_reg_one_r;
   reg  [7:0]  config_reg_seven_r;
   reg  [7:0]  ppmode_r;
   reg         rxd_s1_r;
   reg         rxd_s2_r;
   reg         rxd_s3_r;
   reg         ri_s1_r;
   reg         ri_s2_r;
   reg         ri_s3_r;
   reg  [1:0]  tx_state_r;
   reg  [1:0]  tx_state_nxt;
   reg  [1:0]  rx_state_r;
   reg  [1:0]  rx_state_nxt;
   reg  [31:0] rd_nxt;
   wire        wb_req;
   wire        wb_wr;
   wire        wr_cr1;
   wire        wr_cr7;
   wire        wr_ppmode;
   wire        ser_apm;
   wire        pp_apm;
   wire        epp_en;
   wire        ecp_en;
   wire [2:0]  ecr_mode;
   wire        epp_pd_nxt;
   wire        ecp_pd_nxt;
   wire        rx_edge;
   wire        ri_edge;
   wire        tx_empty;
   wire        rx_quiet;
   wire [5:0]  status_nxt;

   ////////////////////////////////////////////////////////////////
   // address match against a register offset
   function addr_hit;
      input [7:0] adr;
      input [7:0] offset;
      begin
         addr_hit = (adr == offset);
      end
   endfunction

   // ecr field holds the given mode code
   function ecr_is;
      input [2:0] mode;
      input [2:0] code;
      begin
         ecr_is = (mode == code);
      end
   endfunction

   // epp unused: disabled, or ecp mode with ecr off epp
   function epp_idle;
      input       epp_on;
      input       ecp_on;
      input [2:0] mode;
      begin
         epp_idle = ~epp_on | (ecp_on & ~ecr_is(mode, `SPAPD_ECR_EPP));
      end
   endfunction

   // ecp unused: disabled, or ecr picks spp, bidir or epp
   function ecp_idle;
      input       ecp_on;
      input [2:0] mode;
      begin
         ecp_idle = ~ecp_on | ecr_is(mode, `SPAPD_ECR_SPP) | ecr_is(mode, `SPAPD_ECR_BIDIR)
                  | ecr_is(mode, `SPAPD_ECR_EPP);
      end
   endfunction

   ////////////////////////////////////////////////////////////////
   assign wb_req     = wb_cyc_in & wb_stb_in & ~wb_ack_out;
   assign wb_wr      = wb_req & wb_we_in & wb_sel_in[0];
   assign wr_cr1     = wb_wr & addr_hit(wb_adr_in, `SPAPD_ADDR_CR1);
   assign wr_cr7     = wb_wr & addr_hit(wb_adr_in, `SPAPD_ADDR_CR7);
   assign wr_ppmode  = wb_wr & addr_hit(wb_adr_in, `SPAPD_ADDR_PPMODE);
   assign ser_apm    = config_reg_seven_r[`SPAPD_CR7_SER_APM_LO]
                     | config_reg_seven_r[`SPAPD_CR7_SER_APM_HI];
   assign pp_apm     = config_reg_seven_r[`SPAPD_CR7_PP_APM];
   assign epp_en     = ppmode_r[`SPAPD_PM_EPP_EN];
   assign ecp_en     = ppmode_r[`SPAPD_PM_ECP_EN];
   assign ecr_mode   = ppmode_r[`SPAPD_PM_ECR_HI:`SPAPD_PM_ECR_LO];
   // apm clear keeps both parallel blocks powered
   assign epp_pd_nxt = pp_apm & epp_idle(epp_en, ecp_en, ecr_mode);
   assign ecp_pd_nxt = pp_apm & ecp_idle(ecp_en, ecr_mode);
   assign rx_edge    = rxd_s2_r ^ rxd_s3_r;
   assign ri_edge    = ri_s2_r ^ ri_s3_r;
   assign tx_empty   = thb_empty_in & tsr_empty_in;
   assign rx_quiet   = rx_fifo_empty_in & rx_idle_in;
   assign status_nxt = {ri_s2_r, pp_pd_out, ecp_pd_out, epp_pd_out, rx_pd_out, tx_pd_out};

   ////////////////////////////////////////////////////////////////
   // read data for the addressed register, zero elsewhere
   always @* begin
      rd_nxt = 32'h00000000;
      case (wb_adr_in)
         `SPAPD_ADDR_CR1:    rd_nxt[7:0] = config_reg_one_r;
         `SPAPD_ADDR_CR7:    rd_nxt[7:0] = config_reg_seven_r;
         `SPAPD_ADDR_PPMODE: rd_nxt[7:0] = ppmode_r;
         `SPAPD_ADDR_STATUS: rd_nxt[5:0] = status_nxt;
         default:            rd_nxt = 32'h00000000;
      endcase
   end

   ////////////////////////////////////////////////////////////////
   // transmitter: a holding buffer write beats sleep
   always @* begin
      tx_state_nxt = tx_state_r;
      case (tx_state_r)
         SER_AWAKE: begin
            if (ser_apm && !thb_write_in && tx_empty) begin
               tx_state_nxt = SER_ASLEEP;
            end
         end
         SER_ASLEEP: begin
            if (!ser_apm || thb_write_in) begin
               tx_state_nxt = SER_AWAKE;
            end
         end
         default: tx_state_nxt = SER_AWAKE;
      endcase
   end

   // receiver: a level change on the rx input beats sleep
   always @* begin
      rx_state_nxt = rx_state_r;
      case (rx_state_r)
         SER_AWAKE: begin
            if (ser_apm && !rx_edge && rx_quiet) begin
               rx_state_nxt = SER_ASLEEP;
            end
         end
         SER_ASLEEP: begin
            if (!ser_apm || rx_edge) begin
               rx_state_nxt = SER_AWAKE;
            end
         end
         default: rx_state_nxt = SER_AWAKE;
      endcase
   end

   ////////////////////////////////////////////////////////////////
   // config_reg_one, low byte only
   always @(posedge clk_in) begin
      if (rst_in) begin
         config_reg_one_r <= `SPAPD_CR1_RESET;
      end else if (ce_in) begin
         if (wr_cr1)
            config_reg_one_r <= wb_dat_in[7:0];
      end
   end

   ////////////////////////////////////////////////////////////////
   // config_reg_seven, low byte only
   always @(posedge clk_in) begin
      if (rst_in) begin
         config_reg_seven_r <= `SPAPD_CR7_RESET;
      end else if (ce_in) begin
         if (wr_cr7)
            config_reg_seven_r <= wb_dat_in[7:0];
      end
   end

   ////////////////////////////////////////////////////////////////
   // mode and ecr writes re-evaluate parallel powerdown next edge
   always @(posedge clk_in) begin
      if (rst_in) begin
         ppmode_r <= `SPAPD_PM_RESET;
      end else if (ce_in) begin
         if (wr_ppmode)
            ppmode_r <= wb_dat_in[7:0];
      end
   end

   ////////////////////////////////////////////////////////////////
   // bus answer one cycle after the request is taken
   always @(posedge clk_in) begin
      if (rst_in) begin
         wb_ack_out <= 1'b0;
         wb_dat_out <= 32'h00000000;
      end else if (ce_in) begin
         wb_ack_out <= wb_req;
         if (wb_req)
            wb_dat_out <= rd_nxt;
         else
            wb_dat_out <= 32'h00000000;
      end
   end

   ////////////////////////////////////////////////////////////////
   // rx pin: two stages before use, third only for edges
   always @(posedge clk_in) begin
      if (rst_in) begin
         rxd_s1_r <= 1'b1;
         rxd_s2_r <= 1'b1;
         rxd_s3_r <= 1'b1;
      end else if (ce_in) begin
         rxd_s1_r <= serial_rx_input_in;
         rxd_s2_r <= rxd_s1_r;
         rxd_s3_r <= rxd_s2_r;
      end
   end

   ////////////////////////////////////////////////////////////////
   // ring pin: two stages before use, third only for edges
   always @(posedge clk_in) begin
      if (rst_in) begin
         ri_s1_r <= 1'b0;
         ri_s2_r <= 1'b0;
         ri_s3_r <= 1'b0;
      end else if (ce_in) begin
         ri_s1_r <= ring_in;
         ri_s2_r <= ri_s1_r;
         ri_s3_r <= ri_s2_r;
      end
   end

   ////////////////////////////////////////////////////////////////
   // transmitter powerdown
   always @(posedge clk_in) begin
      if (rst_in) begin
         tx_state_r <= SER_AWAKE;
         tx_pd_out  <= 1'b0;
      end else if (ce_in) begin
         tx_state_r <= tx_state_nxt;
         tx_pd_out  <= (tx_state_nxt == SER_ASLEEP);
      end
   end

   ////////////////////////////////////////////////////////////////
   // receiver powerdown
   always @(posedge clk_in) begin
      if (rst_in) begin
         rx_state_r <= SER_AWAKE;
         rx_pd_out  <= 1'b0;
      end else if (ce_in) begin
         rx_state_r <= rx_state_nxt;
         rx_pd_out  <= (rx_state_nxt == SER_ASLEEP);
      end
   end

   ////////////////////////////////////////////////////////////////
   // ring detection ignores powerdown state
   always @(posedge clk_in) begin
      if (rst_in) begin
         ri_change_out <= 1'b0;
      end else if (ce_in) begin
         ri_change_out <= ri_edge;
      end
   end

   ////////////////////////////////////////////////////////////////
   // parallel powerdown outputs
   always @(posedge clk_in) begin
      if (rst_in) begin
         epp_pd_out <= 1'b0;
         ecp_pd_out <= 1'b0;
         pp_pd_out  <= 1'b0;
      end else if (ce_in) begin
         epp_pd_out <= epp_pd_nxt;
         ecp_pd_out <= ecp_pd_nxt;
         pp_pd_out  <= config_reg_one_r[`SPAPD_CR1_PP_PWR];
      end
   end
endmodule

// *** design/spapd_defines.vh ***
`ifndef SPAPD_DEFINES_VH
`define SPAPD_DEFINES_VH
// wishbone word offsets (byte addresses)
`define SPAPD_ADDR_CR1        8'h00
`define SPAPD_ADDR_CR7        8'h04
`define SPAPD_ADDR_PPMODE     8'h08
`define SPAPD_ADDR_STATUS     8'h0C
// config_reg_one fields
`define SPAPD_CR1_PP_PWR      2
`define SPAPD_CR1_RESET       8'h9C
// config_reg_seven fields
`define SPAPD_CR7_PP_APM      4
`define SPAPD_CR7_SER_APM_LO  5
`define SPAPD_CR7_SER_APM_HI  6
`define SPAPD_CR7_RESET       8'h00
// parallel mode register fields
`define SPAPD_PM_EPP_EN       0
`define SPAPD_PM_ECP_EN       1
`define SPAPD_PM_ECR_LO       2
`define SPAPD_PM_ECR_HI       4
`define SPAPD_PM_RESET        8'h00
// ecr mode encodings
`define SPAPD_ECR_SPP         3'h0
`define SPAPD_ECR_BIDIR       3'h1
`define SPAPD_ECR_EPP         3'h4
// status fields
`define SPAPD_ST_TX_PD        0
`define SPAPD_ST_RX_PD        1
`define SPAPD_ST_EPP_PD       2
`define SPAPD_ST_ECP_PD       3
`define SPAPD_ST_PP_PD        4
`define SPAPD_ST_RI           5
`endif

// *** test/spapd_ctrl_props.sv ***
`timescale 1ns/1ns
module spapd_ctrl_props (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic wb_cyc_in,
   input wire logic wb_stb_in,
   input wire logic wb_we_in,
   input wire logic wb_ack_out,
   input wire logic thb_write_in,
   input wire logic thb_empty_in,
   input wire logic tsr_empty_in,
   input wire logic serial_rx_input_in,
   input wire logic ring_in,
   input wire logic tx_pd_out,
   input wire logic rx_pd_out,
   input wire logic epp_pd_out,
   input wire logic ri_change_out
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (rst_in);
   a_tx_wake_up: assert property (thb_write_in |=> !tx_pd_out) else $error("tx still down");
   a_rx_wake_up: assert property ($changed(serial_rx_input_in) |-> ##[1:5] !rx_pd_out) else $error("rx asleep");
   a_tx_sleep_cause: assert property ($rose(tx_pd_out) |-> $past(thb_empty_in && tsr_empty_in && !thb_write_in))
      else $error("tx slept busy");
   a_epp_mode_change: assert property ($changed(epp_pd_out) |-> wb_ack_out && wb_we_in || $past(wb_ack_out && wb_we_in))
      else $error("epp moved alone");
   a_ring_edge: assert property ($changed(ring_in) |-> ##[1:5] ri_change_out) else $error("ring lost");
   a_ring_pulse: assert property (ri_change_out |=> !ri_change_out) else $error("ring pulse long");
   a_ack_reply: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out) else $error("no ack");
   a_ack_single: assert property (wb_ack_out |=> !wb_ack_out) else $error("ack long");
endmodule
bind spapd_ctrl spapd_ctrl_props spapd_ctrl_props_inst (.*);

// *** test/serial_parallel_auto_powerdown_tb_top.sv ***
`timescale 1ns/1ns
`include "spapd_defines.vh"
module serial_parallel_auto_powerdown_tb_top;
   logic        clk_in = 0, rst_in = 1, cyc = 0, we = 0, thw = 0, emp = 1, srx = 1, ring = 0, ce = 1, idle = 1;
   logic [7:0]  adr = 0;
   logic [31:0] wd = 0, rv, q;
   wire         ack, txp, rxp, eppp, ecpp, ppp, ric;
   integer      mismatches = 0, num_checks = 0, rings = 0, m, a;
   always #25 clk_in = ~clk_in;
   always @(posedge clk_in) if (ric === 1'h1) rings++;
   spapd_ctrl spapd_ctrl_inst (.clk_in(clk_in), .rst_in(rst_in), .ce_in(ce), .wb_cyc_in(cyc), .wb_stb_in(cyc),
      .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(4'hF), .wb_dat_in(wd), .wb_dat_out(q), .wb_ack_out(ack),
      .thb_write_in(thw), .thb_empty_in(emp), .tsr_empty_in(emp), .rx_fifo_empty_in(emp), .rx_idle_in(idle),
      .serial_rx_input_in(srx), .ring_in(ring), .tx_pd_out(txp), .rx_pd_out(rxp), .epp_pd_out(eppp),
      .ecp_pd_out(ecpp), .pp_pd_out(ppp), .ri_change_out(ric));
   task chk(input logic [31:0] g, input logic [31:0] e);
      num_checks++;
      if (g !== e) begin
         mismatches++;
         $display("mismatch at %0t: got %h want %h", $time, g, e);
      end
   endtask
   task conclude;
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   // one wishbone cycle, waits for ack
   task acc(input logic w, input logic [7:0] ad, input logic [31:0] d);
      @(posedge clk_in);
      cyc <= 1; we <= w; adr <= ad; wd <= d;
      do @(posedge clk_in); while (ack !== 1'h1);
      rv = q;
      cyc <= 0; we <= 0;
   endtask
   initial begin
      #500000;
      mismatches++;
      conclude;
   end
   initial begin
      repeat (6) @(posedge clk_in);
      rst_in <= 0;
      acc(0, `SPAPD_ADDR_CR1, 0); chk(rv, 32'h9C);
      acc(0, `SPAPD_ADDR_CR7, 0); chk(rv, 32'h0);
      acc(0, `SPAPD_ADDR_STATUS, 0); chk(rv, 32'h10);
      acc(1, `SPAPD_ADDR_CR1, 32'h98); acc(0, `SPAPD_ADDR_STATUS, 0); chk(rv, 32'h0);
      acc(1, 8'h10, 32'hFF); chk(rv, 32'h0);
      for (a = 0; a < 2; a++) begin
         acc(1, `SPAPD_ADDR_CR7, a << 4);
         for (m = 0; m < 32; m++) begin
            acc(1, `SPAPD_ADDR_PPMODE, m);
            acc(0, `SPAPD_ADDR_STATUS, 0);
            chk(rv[3:2], {a[0] & (!m[1] | m[4:2] < 2 | m[4:2] == 4), a[0] & (!m[0] | (m[1] & m[4:2] != 4))});
         end
      end
      for (a = 1; a < 3; a++) begin
         acc(1, `SPAPD_ADDR_CR7, 32'h10 << a);
         acc(0, `SPAPD_ADDR_STATUS, 0); chk(rv[1:0], 2'h3);
      end
      ring <= 1;
      repeat (8) @(posedge clk_in);
      ring <= 0;
      repeat (8) @(negedge clk_in); chk(rings, 2);
      @(posedge clk_in) thw <= 1;
      @(posedge clk_in) thw <= 0;
      @(negedge clk_in) chk(txp, 0);
      @(posedge clk_in) begin thw <= 1; emp <= 0; end
      @(posedge clk_in) thw <= 0;
      repeat (4) @(negedge clk_in); chk({rxp, txp}, 2'h2);
      @(posedge clk_in) srx <= 0;
      repeat (6) @(negedge clk_in); chk(rxp, 0);
      @(posedge clk_in) begin emp <= 1; idle <= 0; end
      repeat (4) @(negedge clk_in); chk({rxp, txp}, 2'h1);
      @(posedge clk_in) begin ce <= 0; idle <= 1; end
      repeat (4) @(negedge clk_in); chk(rxp, 0);
      @(posedge clk_in) ce <= 1;
      repeat (4) @(negedge clk_in); chk(rxp, 1);
      acc(1, `SPAPD_ADDR_CR7, 32'h0); acc(0, `SPAPD_ADDR_STATUS, 0); chk(rv[1:0], 2'h0);
      conclude;
   end
endmodule
